//--- logic/fts_fir_seq.sv
/*
 * fir tap sequencer: runs repeat-prefixed fir taps with coefficients and
 * samples both read from data memory, 32-bit accumulation.
 * assumes the sequencer supplies the two pointer values and a circular
 * buffer span, and that data memory returns read data in the same cycle
 * as the registered address.
 */
`timescale 1ns/1ns

// Function
// [RULE_01] both coefficient and sample of every tap come from data memory.
// [RULE_02] the even pointer addresses coefficients first, its odd partner samples second.
// [RULE_03] software always issues the filter under a repeat prefix whose count sets the taps.
// [RULE_04] each tap multiplies a 16-bit coefficient by a 16-bit sample read indirectly.
// [RULE_05] products sum into 32 bits and the sample pointer wraps circularly.
// [RULE_06] each tap takes two instruction cycles.
// [RULE_07] software names only an even pointer; its odd partner is used implicitly.
// [RULE_08] interrupts are held pending while the filter runs.
// [RULE_09] a repeat count of zero still computes two taps.
// [RULE_10] the result goes to the selected accumulator with status flags untouched.
// [RULE_11] after the last tap the program counter advances by one and held interrupts resume.
module fts_fir_seq (
	input  wire logic                          clk_in,
	input  wire logic                          resetn_in,
	input  wire logic                          start_in,
	input  wire logic [fts_pkg::CNT_W-1:0]     repeat_prefix_in,
	input  wire logic [fts_pkg::ASEL_W-1:0]    accumulator_select_in,
	input  wire logic [fts_pkg::ADDR_W-1:0]    coef_ptr_in,
	input  wire logic [fts_pkg::ADDR_W-1:0]    samp_ptr_in,
	input  wire logic [fts_pkg::ADDR_W-1:0]    circ_base_in,
	input  wire logic [fts_pkg::ADDR_W-1:0]    circ_len_in,
	input  wire logic [fts_pkg::DATA_W-1:0]    mem_rdata_in,
	output logic      [fts_pkg::ADDR_W-1:0]    mem_addr_out,
	output logic                               mem_rd_out,
	output logic                               busy_out,
	output logic                               int_hold_out,
	output logic                               acc_we_out,
	output logic      [fts_pkg::ASEL_W-1:0]    acc_sel_out,
	output logic      [fts_pkg::ACC_W-1:0]     acc_data_out,
	output logic                               pc_inc_out,
	output logic                               flags_we_out
);

	// ****************************************
	// state
	// ****************************************
	fts_pkg::fts_state_t                state_q;
	logic [fts_pkg::CNT_W:0]            taps_q;
	logic [fts_pkg::ADDR_W-1:0]         coef_q;
	logic [fts_pkg::ADDR_W-1:0]         samp_q;
	logic [fts_pkg::DATA_W-1:0]         coef_word_q;
	logic [fts_pkg::ACC_W-1:0]          acc_q;
	logic [fts_pkg::ASEL_W-1:0]         sel_q;
	logic                               last_q;

	function automatic logic [fts_pkg::ADDR_W-1:0] circ_next(
		input logic [fts_pkg::ADDR_W-1:0] a,
		input logic [fts_pkg::ADDR_W-1:0] base,
		input logic [fts_pkg::ADDR_W-1:0] len
	);
		logic [fts_pkg::ADDR_W-1:0] n;
		n = a + fts_pkg::ONE_ADDR;
		if (n >= base + len) begin
			n = base;
		end
		return n;
	endfunction

	// signed 16x16 product, both operands sign-extended to 32 bits first
	function automatic logic [fts_pkg::ACC_W-1:0] mul16(
		input logic [fts_pkg::DATA_W-1:0] a,
		input logic [fts_pkg::DATA_W-1:0] b
	);
		logic [fts_pkg::ACC_W-1:0] wa;
		logic [fts_pkg::ACC_W-1:0] wb;
		wa = {{(fts_pkg::ACC_W-fts_pkg::DATA_W){a[fts_pkg::DATA_W-1]}}, a};
		wb = {{(fts_pkg::ACC_W-fts_pkg::DATA_W){b[fts_pkg::DATA_W-1]}}, b};
		return wa * wb;
	endfunction

	// a start request is taken only in idle
	function automatic logic launch(
		input fts_pkg::fts_state_t st,
		input logic                go
	);
		return (st == fts_pkg::FTS_IDLE) && go;
	endfunction

	// busy next cycle: set on launch, cleared by the write cycle
	function automatic logic busy_next(
		input fts_pkg::fts_state_t st,
		input logic                go
	);
		return (st == fts_pkg::FTS_IDLE) ? go : (st != fts_pkg::FTS_WRITE);
	endfunction

	// ****************************************
	// tap sequencing
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= fts_pkg::FTS_IDLE;
			taps_q  <= '0;
			last_q  <= 1'b0;
			sel_q   <= '0;
		end else begin
			unique case (state_q)
				fts_pkg::FTS_IDLE: begin
					if (start_in) begin
						state_q <= fts_pkg::FTS_COEF;
						// count n yields n+2 taps, so zero gives two
						taps_q  <= {1'b0, repeat_prefix_in} + 9'h001; // [RULE_09]
						sel_q   <= accumulator_select_in;
						last_q  <= 1'b0;
					end
				end
				fts_pkg::FTS_COEF: begin
					state_q <= fts_pkg::FTS_SAMP; // [RULE_06]
					last_q  <= (taps_q == '0);
				end
				fts_pkg::FTS_SAMP: begin
					if (last_q) begin
						state_q <= fts_pkg::FTS_WRITE;
					end else begin
						state_q <= fts_pkg::FTS_COEF;
						taps_q  <= taps_q - 9'h001;
					end
				end
				fts_pkg::FTS_WRITE: begin
					state_q <= fts_pkg::FTS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// pointers and memory reads
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			coef_q       <= fts_pkg::ADDR_RST;
			samp_q       <= fts_pkg::ADDR_RST;
			mem_addr_out <= fts_pkg::ADDR_RST;
			mem_rd_out   <= 1'b0;
		end else begin
			mem_rd_out <= 1'b0;
			if (launch(state_q, start_in)) begin
				// coefficient read from data memory first
				mem_addr_out <= coef_ptr_in; // [RULE_01] [RULE_02] [RULE_07]
				mem_rd_out   <= 1'b1;
				coef_q       <= coef_ptr_in + fts_pkg::ONE_ADDR;
				samp_q       <= samp_ptr_in;
			end else if (state_q == fts_pkg::FTS_COEF) begin
				// sample read via odd partner, circular
				mem_addr_out <= samp_q; // [RULE_01] [RULE_02]
				mem_rd_out   <= 1'b1;
				samp_q       <= circ_next(samp_q, circ_base_in, circ_len_in); // [RULE_05]
			end else if (state_q == fts_pkg::FTS_SAMP && !last_q) begin
				mem_addr_out <= coef_q; // [RULE_02]
				mem_rd_out   <= 1'b1;
				coef_q       <= coef_q + fts_pkg::ONE_ADDR;
			end
		end
	end

	// ****************************************
	// multiply and accumulate
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			coef_word_q <= '0;
			acc_q       <= fts_pkg::ACC_RST;
		end else begin
			if (launch(state_q, start_in)) begin
				acc_q <= fts_pkg::ACC_RST;
			end else if (state_q == fts_pkg::FTS_COEF) begin
				coef_word_q <= mem_rdata_in;
			end else if (state_q == fts_pkg::FTS_SAMP) begin
				acc_q <= acc_q + mul16(coef_word_q, mem_rdata_in); // [RULE_04] [RULE_05]
			end
		end
	end

	// ****************************************
	// busy and interrupt hold
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_out     <= 1'b0;
			int_hold_out <= 1'b0;
		end else begin
			busy_out     <= busy_next(state_q, start_in);
			// interrupts stay pending for the whole run
			int_hold_out <= busy_next(state_q, start_in); // [RULE_08]
		end
	end

	// ****************************************
	// result write and program counter step
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc_we_out   <= 1'b0;
			acc_sel_out  <= '0;
			acc_data_out <= fts_pkg::ACC_RST;
			pc_inc_out   <= 1'b0;
		end else begin
			acc_we_out   <= (state_q == fts_pkg::FTS_WRITE); // [RULE_10]
			// held interrupts are released with this step
			pc_inc_out   <= (state_q == fts_pkg::FTS_WRITE); // [RULE_11]
			if (state_q == fts_pkg::FTS_WRITE) begin
				acc_sel_out  <= sel_q; // [RULE_10]
				acc_data_out <= acc_q;
			end
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_we_out <= 1'b0;
		end else begin
			// the filter never writes status flags
			flags_we_out <= 1'b0; // [RULE_10]
		end
	end

endmodule

//--- logic/fts_pkg.sv
/*
 * shared constants for the ram-coefficient fir tap sequencer.
 * assumes a single core clock and a single-cycle data memory read.
 */
package fts_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	localparam int ACC_W  = 32;
	localparam int CNT_W  = 8;
	localparam int ASEL_W = 2;
	localparam int PTR_W  = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int TAP_CYCLES = 2;

	// ****************************************
	// reset values and address step
	// ****************************************
	localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
	localparam logic [ADDR_W-1:0] ONE_ADDR = 16'h0001;

	typedef enum logic [1:0] {
		FTS_IDLE  = 2'b00,
		FTS_COEF  = 2'b01,
		FTS_SAMP  = 2'b10,
		FTS_WRITE = 2'b11
	} fts_state_t;

endpackage

//--- test/fts_mem_model.sv
/* data memory model for the fir tap sequencer.
   assumes read data follows the registered address within the cycle,
   image indexed by low address bits. */
`timescale 1ns/1ns
module fts_mem_model (
	input  wire logic [15:0] addr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out
);
	logic [15:0] mem [256];
	// data while strobed, inverted garbage otherwise
	assign rdata_out = rd_in ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
endmodule

//--- test/fts_fir_seq_assertions.sv
/* port checker for fts_fir_seq.
   assumes single clock, async active-low reset. */
`timescale 1ns/1ns
module fts_fir_seq_chk (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic        start_in,
	input wire logic [1:0]  accumulator_select_in,
	input wire logic [15:0] coef_ptr_in,
	input wire logic [15:0] mem_addr_out,
	input wire logic        mem_rd_out,
	input wire logic        busy_out,
	input wire logic        int_hold_out,
	input wire logic        acc_we_out,
	input wire logic [1:0]  acc_sel_out,
	input wire logic        pc_inc_out,
	input wire logic        flags_we_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic [1:0] sel_q;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_q <= 2'h0;
		end else if (start_in && !busy_out) begin
			sel_q <= accumulator_select_in;
		end
	end
	// a start is taken only when not busy, which is idle only; busy is already low in the acc_we_out cycle
	sequence s_launch; start_in && !busy_out; endsequence
	sequence s_coef_rd;
		busy_out && mem_rd_out && mem_addr_out == $past(coef_ptr_in);
	endsequence
	a_launch_reads_coef: assert property (s_launch |=> s_coef_rd) else $error("coef");
	a_hold_tracks_busy: assert property (int_hold_out == busy_out) else $error("hold");
	a_flags_untouched: assert property (!flags_we_out) else $error("flags");
	a_pc_with_write: assert property (pc_inc_out == acc_we_out) else $error("pc");
	a_write_ends_busy: assert property ($fell(busy_out) |-> acc_we_out) else $error("end");
	a_write_one_cycle: assert property (
		acc_we_out |=> !acc_we_out && busy_out == $past(start_in)) else $error("we");
	a_write_sel: assert property (acc_we_out |-> acc_sel_out == sel_q) else $error("sel");
	a_two_taps_min: assert property (s_launch |=> busy_out [*5]) else $error("taps");
endmodule
bind fts_fir_seq fts_fir_seq_chk chk_u (.clk_in, .resetn_in, .start_in, .accumulator_select_in,
	.coef_ptr_in, .mem_addr_out, .mem_rd_out, .busy_out, .int_hold_out, .acc_we_out,
	.acc_sel_out, .pc_inc_out, .flags_we_out);

//--- test/tb_fts_fir_seq.sv
/* bench for fts_fir_seq with a data memory model.
   assumes the checker file is compiled alongside. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_fts_fir_seq;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        start_in = 1'b0;
	logic [7:0]  rep = 8'h00;
	logic [1:0]  sel = 2'h0;
	logic [15:0] coef = 16'h0000, samp = 16'h0000, base = 16'h0000, len = 16'h0001;
	logic [15:0] rdata, addr;
	logic        rd, busy, hold, we, pc, flg;
	logic [1:0]  asel;
	logic [31:0] acc;
	int          n_errors = 0, cmp_count = 0, rd_n = 0, cyc = 0;
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (rd === 1'b1) rd_n++;
		if (cyc == 10000) begin n_errors++; report_and_stop(); end
	end
	fts_fir_seq dut_u (.clk_in, .resetn_in, .start_in, .repeat_prefix_in(rep),
		.accumulator_select_in(sel), .coef_ptr_in(coef), .samp_ptr_in(samp),
		.circ_base_in(base), .circ_len_in(len), .mem_rdata_in(rdata), .mem_addr_out(addr),
		.mem_rd_out(rd), .busy_out(busy), .int_hold_out(hold), .acc_we_out(we),
		.acc_sel_out(asel), .acc_data_out(acc), .pc_inc_out(pc), .flags_we_out(flg));
	fts_mem_model mem_u (.addr_in(addr), .rd_in(rd), .rdata_out(rdata));
	function automatic logic [31:0] fir_ref(input logic [7:0] n, input logic [15:0] c, s, b, l);
		logic [31:0] a, x, y;
		a = 32'h0000_0000;
		for (int t = 0; t < n + 2; t++) begin
			x = 32'($signed(mem_u.mem[c[7:0]]));
			y = 32'($signed(mem_u.mem[s[7:0]]));
			a = a + x * y;
			c = c + 16'h0001;
			s = (s + 16'h0001 >= b + l) ? b : s + 16'h0001;
		end
		return a;
	endfunction
	task automatic run(input logic [7:0] n, input logic [15:0] c, s, b, l);
		logic [31:0] e;
		logic [1:0]  sl;
		int          k;
		sl = 2'($urandom);
		e = fir_ref(n, c, s, b, l);
		@(negedge clk_in);
		rep = n;
		sel = sl;
		coef = c;
		samp = s;
		base = b;
		len = l;
		start_in = 1'b1;
		rd_n = 0;
		@(negedge clk_in);
		start_in = 1'b0;
		repeat (2) @(negedge clk_in);
		`CHK("int_hold", 1'b1, hold)
		`CHK("busy", 1'b1, busy)
		start_in = 1'b1;
		sel = ~sl;
		coef = ~c;
		@(negedge clk_in);
		start_in = 1'b0;
		k = 0;
		while (we !== 1'b1 && k < 600) begin @(negedge clk_in); k++; end
		`CHK("acc_data", e, acc)
		`CHK("acc_sel", sl, asel)
		`CHK("flags_we", 1'b0, flg)
		`CHK("pc_inc", 1'b1, pc)
		`CHK("int_hold_end", 1'b0, hold)
		`CHK("reads", 2 * (n + 2), rd_n)
		`CHK("cycles", fts_pkg::TAP_CYCLES * (n + 2) - 2, k)
	endtask
	task automatic report_and_stop();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		logic [15:0] b, l;
		void'($urandom(32'h92ca_131a));
		for (int i = 0; i < 256; i++) mem_u.mem[i] = 16'($urandom);
		repeat (4) @(negedge clk_in);
		resetn_in = 1'b1;
		run(8'h00, 16'h0010, 16'h0040, 16'h0040, 16'h0001);
		run(8'hff, 16'h00fe, 16'h0063, 16'h0050, 16'h0014);
		// reset cuts a run short
		@(negedge clk_in);
		coef = 16'h0020;
		start_in = 1'b1;
		@(negedge clk_in);
		start_in = 1'b0;
		repeat (2) @(negedge clk_in);
		resetn_in = 1'b0;
		@(negedge clk_in);
		`CHK("busy_rst", 1'b0, busy)
		`CHK("hold_rst", 1'b0, hold)
		`CHK("we_rst", 1'b0, we)
		resetn_in = 1'b1;
		for (int i = 0; i < 40; i++) begin
			b = 16'($urandom_range(0, 150));
			l = 16'($urandom_range(1, 40));
			run(8'($urandom_range(0, 20)), 16'($urandom_range(0, 127) * 2),
				b + 16'($urandom_range(0, l - 1)), b, l);
		end
		report_and_stop();
	end
endmodule
